// ### design/isi_pkg.sv
// Constants and helper functions for the ISA system interface block
`default_nettype none
package isi_pkg;
  // Register window geometry
  localparam int BANKS = 3;
  localparam int REGS_PER_BANK = 16;
  localparam int WORDS_PER_BANK = 8;
  // Register indices within the 16-byte window
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_TX_CP = 4'h1;
  localparam logic [3:0] REG_IRQ_SEL = 4'h2;
  localparam logic [3:0] REG_RX_THRESH = 4'h7;
  localparam logic [3:0] REG_CONFIG = 4'h2;
  localparam logic [3:0] REG_IO_BASE = 4'h3;
  localparam logic [3:0] REG_ROM_BASE = 4'h5;
  // Banks that hold the concurrent processing controls
  localparam logic [1:0] BANK_RX = 2'h1;
  localparam logic [1:0] BANK_CFG = 2'h2;
  localparam logic [1:0] BANK_LAST = 2'h2;
  // Field positions
  localparam int CMD_PTR_LSB = 6;
  localparam int TX_CP_BIT = 0;
  localparam int CFG_SOFT_BASE = 0;
  localparam int CFG_SOFT_PD = 1;
  localparam int CFG_AUTO_RELOC = 2;
  localparam int CFG_PNP_4K = 3;
  localparam int CFG_CONFLICT = 7;
  localparam int EN_BIT = 7;
  // Reset values
  localparam logic [7:0] RX_THRESH_RST = 8'h00;
  localparam logic [7:0] IO_BASE_RST = 8'h30;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Relocation step in 16-byte windows, and strap base table origin
  localparam logic [7:0] RELOC_STEP = 8'h02;
  localparam logic [7:0] STRAP_BASE0 = 8'h20;
  // Time the bus lines must settle before the contention check
  localparam int CONF_WAIT_NS = 30;
  localparam int CLK_NS = 10;
  localparam logic [2:0] CONF_WAIT_CYC = 3'((CONF_WAIT_NS + CLK_NS - 1) / CLK_NS);
  // Cycles the host is held off by the ready line on a read
  localparam logic [2:0] RD_WAIT_CYC = 3'h2;

  // Strap code to window base; each code steps by two windows
  function automatic logic [7:0] strap_base(input logic [2:0] s);
    return STRAP_BASE0 + 8'({s, 1'b0});
  endfunction

  // Window hit in the 1K range, or the 4K range with A10/A11 decoded
  function automatic logic window_hit(input logic [11:0] a, input logic [7:0] base,
                                      input logic wide);
    return wide ? (a[11:4] == base) : (a[9:4] == base[5:0]);
  endfunction
endpackage
`default_nettype wire

// ### design/isi_regmem.sv
// Word-wide register storage for the banked IO window, registered read
`default_nettype none
module isi_regmem
  import isi_pkg::*;
#(
  parameter int DEPTH = BANKS * WORDS_PER_BANK,
  parameter int AW = 5
) (
  // Clock
  input wire logic clk,
  // Write port with byte enables
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [1:0] wr_be,
  input wire logic [15:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [15:0] rd_data
);
  // No reset on the array; registers that need a reset value are shadowed outside
  logic [15:0] mem [DEPTH];

  // Byte lane writes
  always_ff @(posedge clk)
  begin
    if (wr_en && wr_be[0])
      mem[wr_addr][7:0] <= wr_data[7:0];
    if (wr_en && wr_be[1])
      mem[wr_addr][15:8] <= wr_data[15:8];
  end

  // Read data out of a register
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ### design/isi_top.sv
// ISA system interface: IO window decode, banked registers, boot ROM and power-down pins
`default_nettype none
module isi_top
  import isi_pkg::*;
#(
  parameter int AW = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // ISA bus inputs
  input wire logic [AW-1:0] sa,
  input wire logic [15:0] sd_in,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic smemr_n,
  input wire logic aen,
  input wire logic sbhe_n,
  input wire logic bus_reset_input,
  input wire logic bus16_strap,
  // ISA bus outputs
  output logic [15:0] sd_out,
  output logic sd_oe,
  output logic iocs16_n_oe,
  output logic iochrdy_oe,
  output logic [7:0] host_irq_lines,
  output logic [7:0] host_irq_lines_oe,
  // Configuration and power pins
  input wire logic [2:0] io_base_straps,
  input wire logic hw_power_down_request,
  input wire logic [2:0] test_port_in,
  output logic [2:0] test_port_seen,
  // Local memory side
  input wire logic local_mem_req,
  input wire logic eeprom_req,
  input wire logic irq_request,
  output logic boot_rom_select_n,
  output logic buffer_ram_select_n,
  output logic config_eeprom_select,
  output logic select_pull_up,
  output logic eeprom_pull_down,
  // Concurrent processing enables and power state
  output logic tx_concurrent_en,
  output logic rx_concurrent_en,
  output logic powered_down
);
  // Pin inputs gathered into one vector and passed through three flops
  localparam int SW = AW + 16 + 14;
  logic [SW-1:0] pin_s1, pin_s2, pin_s3;
  wire [SW-1:0] pin_raw = {sa, sd_in, ior_n, iow_n, smemr_n, aen, sbhe_n,
    bus_reset_input, bus16_strap, io_base_straps, hw_power_down_request, test_port_in};

  // Synchroniser plus one delay stage for edge detection
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1 <= '1;
      pin_s2 <= '1;
      pin_s3 <= '1;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Field split of the synchronised vector
  wire [AW-1:0] a_now = pin_s2[SW-1 -: AW];
  wire [AW-1:0] a_old = pin_s3[SW-1 -: AW];
  wire [15:0] d_now = pin_s2[29:14];
  wire [15:0] d_old = pin_s3[29:14];
  wire ior_now = ~pin_s2[13];
  wire iow_now = ~pin_s2[12];
  wire iow_old = ~pin_s3[12];
  wire smemr_now = ~pin_s2[11];
  wire aen_old = pin_s3[10];
  wire aen_now = pin_s2[10];
  wire hi_lane_old = ~pin_s3[9];
  wire bus_rst = pin_s2[8];
  wire bus16 = pin_s2[7];
  wire [2:0] straps = pin_s2[6:4];
  wire hw_pd = pin_s2[3];
  wire [2:0] test_s = pin_s2[2:0];

  // Control state
  logic [1:0] bank;
  logic tx_cp;
  logic [7:0] rx_thresh;
  logic [7:0] cfg;
  logic [7:0] soft_base;
  logic [7:0] rom_base;
  logic [7:0] irq_sel;
  logic conflict;
  logic [2:0] rd_cnt;

  // Power state: hardware request idles the ISA pins, software the core and the host IRQ line enables
  wire pd = hw_pd | cfg[CFG_SOFT_PD];
  wire isa_live = ~hw_pd;

  // Window base: software value or strap table
  wire [7:0] base = cfg[CFG_SOFT_BASE] ? soft_base : strap_base(straps);
  wire wide = cfg[CFG_PNP_4K];
  wire hit_now = isa_live && !aen_now && window_hit(a_now[11:0], base, wide);
  wire hit_old = isa_live && !aen_old && window_hit(a_old[11:0], base, wide);

  // Cycle edges; writes finish on the trailing edge of the strobe
  wire wr_done = iow_old && !iow_now && hit_old;
  wire rd_active = ior_now && hit_now;
  wire [3:0] wreg = a_old[3:0];
  wire wide_wr = bus16 && hi_lane_old && !wreg[0];
  wire [7:0] lo_byte = d_old[7:0];
  wire [7:0] hi_byte = wide_wr ? d_old[15:8] : d_old[7:0];
  wire [1:0] wr_be = wide_wr ? 2'h3 : (wreg[0] ? 2'h2 : 2'h1);
  wire [15:0] wr_word = {hi_byte, lo_byte};

  // Per-register write strobes for shadowed registers
  function automatic logic wsel(input logic [3:0] r, input logic [1:0] b, input logic [1:0] bk,
                                input logic [3:0] wr, input logic [1:0] be);
    return (bk == b) && (wr[3:1] == r[3:1]) && be[r[0]];
  endfunction
  function automatic logic [7:0] lane(input logic [3:0] r, input logic [15:0] w);
    return r[0] ? w[15:8] : w[7:0];
  endfunction
  wire cmd_any = (wreg[3:1] == REG_CMD[3:1]) && wr_be[0];
  wire [7:0] cmd_byte = lane(REG_CMD, wr_word);
  wire [1:0] ptr_new = cmd_byte[CMD_PTR_LSB +: 2];
  wire w_txcp = wsel(REG_TX_CP, BANK_CFG, bank, wreg, wr_be);
  wire w_rxth = wsel(REG_RX_THRESH, BANK_RX, bank, wreg, wr_be);
  wire w_cfg = wsel(REG_CONFIG, BANK_CFG, bank, wreg, wr_be);
  wire w_base = wsel(REG_IO_BASE, BANK_CFG, bank, wreg, wr_be);
  wire w_rom = wsel(REG_ROM_BASE, BANK_CFG, bank, wreg, wr_be);
  wire w_irq = wsel(REG_IRQ_SEL, BANK_RX, bank, wreg, wr_be);
  wire [7:0] cfg_byte = lane(REG_CONFIG, wr_word);
  wire [7:0] txcp_byte = lane(REG_TX_CP, wr_word);

  // Contention: our driven data read back different once settled. The readback
  // passes the two-flop synchroniser, so it is compared one cycle after the
  // settle count, when it shows the array data and not the first stale word
  localparam logic [2:0] CONF_SAMPLE_CYC = CONF_WAIT_CYC + 3'h1;
  wire conflict_seen = sd_oe && (rd_cnt == CONF_SAMPLE_CYC) &&
                       (d_now[7:0] != sd_out[7:0]);
  wire conflict_clr = wr_done && w_cfg && cfg_byte[CFG_CONFLICT];

  // Register storage for unshadowed registers
  logic [15:0] mem_rd;
  isi_regmem u_mem (
    .clk(clk),
    .wr_en(wr_done),
    .wr_addr(5'({bank, 3'(wreg[3:1])})),
    .wr_be(wr_be),
    .wr_data(wr_word),
    .rd_addr(5'({bank, 3'(a_now[3:1])})),
    .rd_data(mem_rd)
  );

  // Read view of one register: shadows override the array
  function automatic logic [7:0] rview(input logic [3:0] r, input logic [1:0] b,
                                       input logic [15:0] m);
    logic [7:0] v;
    v = lane(r, m);
    if (r == REG_CMD)
      v = {bank, v[5:0]};
    else if (b == BANK_CFG && r == REG_TX_CP)
      v = {7'h00, tx_cp};
    else if (b == BANK_CFG && r == REG_CONFIG)
      v = {conflict, cfg[6:0]};
    else if (b == BANK_CFG && r == REG_IO_BASE)
      v = base;
    else if (b == BANK_CFG && r == REG_ROM_BASE)
      v = rom_base;
    else if (b == BANK_RX && r == REG_RX_THRESH)
      v = rx_thresh;
    else if (b == BANK_RX && r == REG_IRQ_SEL)
      v = irq_sel;
    return v;
  endfunction
  wire [3:0] rreg = a_now[3:0];
  // Process form, so that the shadow registers read inside the function wake it too
  logic [7:0] rd_lo;
  logic [7:0] rd_hi;
  always_comb
  begin
    rd_lo = rview(rreg, bank, mem_rd);
    rd_hi = rview(rreg | 4'h1, bank, mem_rd);
  end
  wire [15:0] next_sd_out = (bus16 && !rreg[0]) ? {rd_hi, rd_lo} : {rd_lo, rd_lo};

  // Boot ROM decode on 16K blocks
  wire rom_hit = isa_live && smemr_now && !aen_now && rom_base[EN_BIT] &&
                 (a_now[AW-1 -: 6] == rom_base[5:0]);

  // Register updates; bus reset clears them too, and stays live in power-down
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bank <= 2'h0;
      tx_cp <= 1'b0;
      rx_thresh <= RX_THRESH_RST;
      cfg <= ZERO_BYTE;
      soft_base <= IO_BASE_RST;
      rom_base <= ZERO_BYTE;
      irq_sel <= ZERO_BYTE;
    end
    else if (bus_rst)
    begin
      bank <= 2'h0;
      tx_cp <= 1'b0;
      rx_thresh <= RX_THRESH_RST;
      cfg <= ZERO_BYTE;
      soft_base <= IO_BASE_RST;
      rom_base <= ZERO_BYTE;
      irq_sel <= ZERO_BYTE;
    end
    else
    begin
      // Pointer value beyond the last bank is ignored
      if (wr_done && cmd_any && ptr_new <= BANK_LAST)
        bank <= ptr_new;
      if (wr_done && w_txcp)
        tx_cp <= txcp_byte[TX_CP_BIT];
      if (wr_done && w_rxth)
        rx_thresh <= lane(REG_RX_THRESH, wr_word);
      if (wr_done && w_cfg)
        cfg <= {1'b0, cfg_byte[6:0]};
      // Relocation steps two windows on and moves to the software base
      if (conflict_seen && cfg[CFG_AUTO_RELOC])
      begin
        soft_base <= base + RELOC_STEP;
        cfg[CFG_SOFT_BASE] <= 1'b1;
      end
      else if (wr_done && w_base)
        soft_base <= lane(REG_IO_BASE, wr_word);
      if (wr_done && w_rom)
        rom_base <= lane(REG_ROM_BASE, wr_word);
      if (wr_done && w_irq)
        irq_sel <= lane(REG_IRQ_SEL, wr_word);
    end
  end

  // Sticky conflict flag; a new conflict wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      conflict <= 1'b0;
    else if (conflict_seen)
      conflict <= 1'b1;
    else if (conflict_clr || bus_rst)
      conflict <= 1'b0;
  end

  // Read cycle: hold off the host until the array data is through
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_cnt <= 3'h0;
      sd_oe <= 1'b0;
      sd_out <= 16'h0000;
      iochrdy_oe <= 1'b0;
      iocs16_n_oe <= 1'b0;
    end
    else
    begin
      rd_cnt <= rd_active ? (rd_cnt == 3'h7 ? rd_cnt : rd_cnt + 3'h1) : 3'h0;
      sd_oe <= rd_active;
      sd_out <= rd_active ? next_sd_out : sd_out;
      iochrdy_oe <= rd_active && (rd_cnt < RD_WAIT_CYC);
      iocs16_n_oe <= hit_now && bus16 && !a_now[0];
    end
  end

  // Pin states and enables
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      boot_rom_select_n <= 1'b1;
      buffer_ram_select_n <= 1'b1;
      config_eeprom_select <= 1'b0;
      select_pull_up <= 1'b0;
      eeprom_pull_down <= 1'b0;
      test_port_seen <= 3'h0;
      host_irq_lines <= 8'h00;
      host_irq_lines_oe <= 8'h00;
      tx_concurrent_en <= 1'b0;
      rx_concurrent_en <= 1'b0;
      powered_down <= 1'b0;
    end
    else
    begin
      boot_rom_select_n <= pd | ~rom_hit;
      buffer_ram_select_n <= pd | ~local_mem_req;
      select_pull_up <= pd;
      config_eeprom_select <= ~pd & eeprom_req;
      eeprom_pull_down <= pd;
      // Test inputs frozen while powered down so toggling has no effect
      test_port_seen <= pd ? test_port_seen : test_s;
      host_irq_lines <= {8{irq_request}};
      host_irq_lines_oe <= (pd || !irq_sel[EN_BIT]) ? 8'h00 : 8'(8'h01 << irq_sel[2:0]);
      tx_concurrent_en <= tx_cp;
      rx_concurrent_en <= (rx_thresh != ZERO_BYTE);
      powered_down <= pd;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_HWPD_QUIET: assert property (hw_pd |-> ##1 !sd_oe && !iocs16_n_oe)
    else $error("ISA drivers active in hardware power-down");
  AST_SEL_PULLUP: assert property (pd |=> boot_rom_select_n && buffer_ram_select_n && select_pull_up)
    else $error("Memory selects not idle in power-down");
  AST_EE_PULLDN: assert property (pd |=> !config_eeprom_select && eeprom_pull_down)
    else $error("EEPROM select not idle in power-down");
  AST_TEST_FROZEN: assert property (pd && $past(pd) |=> $stable(test_port_seen))
    else $error("Test inputs seen during power-down");
  AST_BUSRST_LIVE: assert property (bus_rst |=> !tx_cp && rx_thresh == RX_THRESH_RST)
    else $error("Bus reset ignored");
  AST_ROM_DECODE: assert property (!boot_rom_select_n |-> $past(rom_hit) && !$past(pd))
    else $error("Boot ROM selected outside its block");
  AST_BANK_RANGE: assert property (bank <= BANK_LAST)
    else $error("Bank pointer out of range");
  AST_AEN_IGNORE: assert property (aen_now |=> !sd_oe)
    else $error("Answered a DMA cycle");
  AST_RX_CP: assert property (##1 rx_concurrent_en == ($past(rx_thresh) != ZERO_BYTE))
    else $error("Receive overlap enable mismatch");
  AST_IRQ_FLOAT: assert property (pd |=> host_irq_lines_oe == 8'h00)
    else $error("IRQ driven in power-down");
  AST_CONFLICT_STICKY: assert property (conflict_seen |=> conflict)
    else $error("Conflict not recorded");
endmodule
`default_nettype wire

// ### dv/isi_host_model.sv
// Behavioural ISA host running IO and memory cycles against the block
`default_nettype none
module isi_host_model (
  // Clock
  input wire logic clk,
  // Lines the block drives
  input wire logic [15:0] sd_out,
  input wire logic sd_oe,
  input wire logic rom_sel_n,
  // Lines the host drives
  output logic [19:0] sa,
  output logic [15:0] sd_in,
  output logic ior_n,
  output logic iow_n,
  output logic smemr_n,
  output logic aen,
  output logic sbhe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host data, inverted once released so a stale byte never reads back
  logic [15:0] drv = 16'h0000;
  // Set by the bench: a second card fights the low byte while the block drives
  logic clash = 1'b0;
  // Device wins the data lines while it drives them, unless a second card clashes
  assign sd_in = sd_oe ? (sd_out ^ {8'h00, {8{clash}}}) : drv;
  // Idle bus at time zero
  initial
  begin
    sa = 20'h00000;
    {ior_n, iow_n, smemr_n, sbhe_n} = 4'hF;
    aen = 1'b0;
  end
  // Strobe 6 clocks, gap 6: above the block's minimum spacing
  task automatic io_wr(input logic [11:0] a, input logic [15:0] d, input logic hb,
                       input logic dma);
    @(posedge clk);
    #1;
    sa = {8'h00, a};
    drv = d;
    sbhe_n = ~hb;
    aen = dma;
    iow_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 iow_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 drv = ~d;
    sa = ~sa;
    aen = 1'b0;
    sbhe_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Read held past the wait state; data taken after the edge settles
  task automatic io_rd(input logic [11:0] a, output logic [15:0] d, output logic o);
    @(posedge clk);
    #1;
    sa = {8'h00, a};
    ior_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    d = sd_out;
    o = sd_oe;
    ior_n = 1'b1;
    repeat (5) @(posedge clk);
    #1 sa = ~sa;
  endtask
  // Memory read, reporting the boot ROM select seen mid-cycle
  task automatic mem_rd(input logic [19:0] a, output logic s);
    @(posedge clk);
    #1;
    sa = a;
    smemr_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    s = rom_sel_n;
    smemr_n = 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### dv/isi_top_tb.sv
// Self-checking bench for the ISA system interface block
`default_nettype none
module isi_top_tb;
  import isi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and bench state
  logic clk = 1'b0;
  logic rstn = 1'b0;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rs = 32'hB2B2;
  // Host bus
  logic [19:0] sa;
  logic [15:0] sd_in, sd_out, rd;
  logic ior_n, iow_n, smemr_n, aen, sbhe_n, sd_oe, ok, sel;
  // Bench driven pins
  logic bus_reset_input = 1'b0, bus16_strap = 1'b1, hw_power_down_request = 1'b0;
  logic local_mem_req = 1'b0, eeprom_req = 1'b0, irq_request = 1'b0;
  logic [2:0] io_base_straps = 3'h0, test_port_in = 3'h0, test_port_seen, st;
  // Outputs under check
  logic iocs16_n_oe, iochrdy_oe, boot_rom_select_n, buffer_ram_select_n;
  logic config_eeprom_select, select_pull_up, eeprom_pull_down;
  logic tx_concurrent_en, rx_concurrent_en, powered_down;
  logic [7:0] host_irq_lines, host_irq_lines_oe, v;
  logic [11:0] base;
  always #5 clk = ~clk;
  isi_top i_isi_top (.clk, .rstn, .sa, .sd_in, .ior_n, .iow_n, .smemr_n, .aen, .sbhe_n,
    .bus_reset_input, .bus16_strap, .sd_out, .sd_oe, .iocs16_n_oe, .iochrdy_oe,
    .host_irq_lines, .host_irq_lines_oe, .io_base_straps, .hw_power_down_request,
    .test_port_in, .test_port_seen, .local_mem_req, .eeprom_req, .irq_request,
    .boot_rom_select_n, .buffer_ram_select_n, .config_eeprom_select, .select_pull_up,
    .eeprom_pull_down, .tx_concurrent_en, .rx_concurrent_en, .powered_down);
  isi_host_model i_isi_host_model (.clk, .sd_out, .sd_oe, .rom_sel_n(boot_rom_select_n),
    .sa, .sd_in, .ior_n, .iow_n, .smemr_n, .aen, .sbhe_n);
  // Xorshift source, fixed seed
  function automatic logic [31:0] nx();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Strap code to IO address of the window
  function automatic logic [11:0] wbase(input logic [2:0] s);
    return 12'h200 + 12'(s) * 12'h020;
  endfunction
  // Case-equality compare
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] r, input logic [15:0] d);
    i_isi_host_model.io_wr(base + 12'(r), d, 1'b0, 1'b0);
  endtask
  task automatic rdr(input logic [3:0] r);
    i_isi_host_model.io_rd(base + 12'(r), rd, ok);
  endtask
  task automatic bank(input logic [1:0] b);
    wr(REG_CMD, {8'h00, b, 6'h00});
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard: the whole run needs about 850 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      give_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    base = wbase(3'h0);
    test_port_in = 3'h5;
    tick(8);
    chk({tx_concurrent_en, rx_concurrent_en}, 2'b00);
    chk(host_irq_lines_oe, 8'h00);
    chk({powered_down, test_port_seen}, 4'h5);
    done("reset");
    // Strap corner 7, then random straps
    for (int i = 0; i < 3; i++)
    begin
      st = (i == 0) ? 3'h7 : 3'(nx());
      io_base_straps = st;
      base = wbase(st);
      tick(4);
      v = 8'(nx()) | 8'h01;
      bank(BANK_RX);
      wr(REG_RX_THRESH, {8'h00, v});
      chk(rx_concurrent_en, 1'b1);
      rdr(REG_RX_THRESH);
      chk(rd[7:0], v);
      bank(BANK_CFG);
      wr(REG_TX_CP, 16'h0001);
      wr(REG_RX_THRESH, 16'h0000);
      chk({tx_concurrent_en, rx_concurrent_en}, 2'b11);
      wr(REG_TX_CP, 16'h0000);
      bank(BANK_RX);
      wr(REG_RX_THRESH, 16'h0000);
      chk({tx_concurrent_en, rx_concurrent_en}, 2'b00);
    end
    done("banks");
    // DMA cycle, foreign window, then an ignored pointer value
    i_isi_host_model.io_wr(base + 12'(REG_RX_THRESH), 16'h0055, 1'b0, 1'b1);
    i_isi_host_model.io_wr(base + 12'h047, 16'h0055, 1'b0, 1'b0);
    chk(rx_concurrent_en, 1'b0);
    i_isi_host_model.io_rd(base + 12'h047, rd, ok);
    chk(ok, 1'b0);
    bank(2'h3);
    wr(REG_RX_THRESH, 16'h0011);
    chk(rx_concurrent_en, 1'b1);
    done("refuse");
    // Word write lands its high byte in register 7
    i_isi_host_model.io_wr(base + 12'h006, 16'h00A5, 1'b1, 1'b0);
    chk(rx_concurrent_en, 1'b0);
    i_isi_host_model.io_wr(base + 12'h006, 16'h5A00, 1'b1, 1'b0);
    i_isi_host_model.io_rd(base + 12'h006, rd, ok);
    chk(rd, 16'h5A00);
    chk(rx_concurrent_en, 1'b1);
    bus16_strap = 1'b0;
    rdr(REG_RX_THRESH);
    chk(rd, 16'h5A5A);
    bus16_strap = 1'b1;
    done("width");
    // Every interrupt line in turn
    for (int k = 0; k < 8; k++)
    begin
      v = 8'(nx());
      irq_request = v[0];
      wr(REG_IRQ_SEL, {8'h00, 8'h80 | 8'(k)});
      chk(host_irq_lines_oe, 8'h01 << k);
      chk(host_irq_lines, {8{irq_request}});
    end
    done("irq");
    bank(BANK_CFG);
    v = 8'(nx()) & 8'h3F;
    wr(REG_ROM_BASE, {8'h00, 8'h80 | v});
    i_isi_host_model.mem_rd({v[5:0], 14'h1234}, sel);
    chk(sel, 1'b0);
    i_isi_host_model.mem_rd({v[5:0] ^ 6'h20, 14'h3FFF}, sel);
    chk(sel, 1'b1);
    done("rom");
    // Software power-down keeps the bus alive
    wr(REG_CONFIG, 16'h0002);
    chk({powered_down, select_pull_up, boot_rom_select_n}, 3'b111);
    rdr(REG_ROM_BASE);
    chk({ok, rd[7:0]}, {1'b1, 8'h80 | v});
    wr(REG_CONFIG, 16'h0000);
    wr(REG_TX_CP, 16'h0001);
    chk(powered_down, 1'b0);
    // Hardware power-down with local requests pending
    local_mem_req = 1'b1;
    eeprom_req = 1'b1;
    hw_power_down_request = 1'b1;
    tick(6);
    chk({boot_rom_select_n, buffer_ram_select_n, select_pull_up}, 3'b111);
    chk({config_eeprom_select, eeprom_pull_down}, 2'b01);
    chk(host_irq_lines_oe, 8'h00);
    test_port_in = 3'h2;
    tick(6);
    chk(test_port_seen, 3'h5);
    rdr(REG_TX_CP);
    chk(ok, 1'b0);
    wr(REG_TX_CP, 16'h0000);
    chk(tx_concurrent_en, 1'b1);
    bus_reset_input = 1'b1;
    tick(5);
    bus_reset_input = 1'b0;
    tick(4);
    chk({tx_concurrent_en, rx_concurrent_en}, 2'b00);
    hw_power_down_request = 1'b0;
    local_mem_req = 1'b0;
    eeprom_req = 1'b0;
    tick(6);
    chk({powered_down, test_port_seen}, 4'h2);
    done("power");
    // A second card answers in our window: flag it and move two windows on
    bank(BANK_CFG);
    wr(REG_CONFIG, 16'h0004);
    i_isi_host_model.clash = 1'b1;
    rdr(REG_CMD);
    i_isi_host_model.clash = 1'b0;
    base = base + 12'h020;
    rdr(REG_CONFIG);
    chk({ok, rd[7:0]}, 9'h185);
    // Clear the flag, keep the software base and widen the decode to 4K
    wr(REG_CONFIG, 16'h0089);
    rdr(REG_IO_BASE);
    chk(rd[7:0], 8'(base >> 4));
    i_isi_host_model.io_rd(base ^ 12'h400, rd, ok);
    chk(ok, 1'b0);
    rdr(REG_CONFIG);
    chk(rd[7:0], 8'h09);
    done("conflict");
    give_verdict();
  end
endmodule
`default_nettype wire
